// File: src/aor_top.sv
// audio output router: one-bit or pcm/hbr data onto six pins, plus master clock.
// register-controlled rotation and mirroring of the pin order.
// assumes framers on i_clk_sys and an ahb-lite master.
`timescale 1ns/1ps

// What this block does
// - rotation moves one-bit channels up the six pins; 110/111 reserved
// - reverse mirrors one-bit channel order
// - rotation and reverse combine freely
// - ch0 and ch1 carry the main stereo pair
// - auto: one-bit packets pick one-bit, hbr packets pick hbr, else serial pcm
// - override forces pcm (select 0) or one-bit (select 1)
// - hbr blocks 0..3 on pins 1..4 at quarter rate
// - hbr override clear gives coded streams
// - override set: select 1 coded, 0 binary in chosen framing
// - override with framing 11 gives aes3 on all hbr pins
// - binary hbr output drives no audio flags
// - pcm rotation and reverse map the hbr pins too
// - first coded stream on pin 0 in pcm and hbr modes
// - hbr select counts only with hbr override set
// - master clock is (n+1)*128 fs, n 000..101
// - framing: 00 i2s, 01 right, 10 left, 11 raw coded
module aor_top (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // receiver side
    input wire aor_pkg::aor_pkt_t i_pkt_type,
    input wire logic [5:0] i_onebit_ch,
    input wire logic [3:0] i_pcm_sd,
    input wire logic [3:0] i_hbr_coded,
    input wire logic [3:0] i_hbr_binary,
    input wire logic [3:0] i_hbr_aes3,
    input wire logic i_coded_stream0,
    // word clock, async to i_clk_sys
    input wire logic i_link_wclk,
    // outputs
    output logic [5:0] o_audio_pin,
    output logic o_master_clock_out,
    output aor_pkg::aor_framing_t o_serial_framing_select,
    output logic [4:0] o_justified_word_width,
    output logic o_audio_flags_en,
    output logic o_hbr_active
);
    import aor_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_ff;
    logic rst_b_ff;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_b_ff <= rst_meta_ff;
        end
    end

    // ************************************************************
    // ahb-lite slave, zero wait states
    // ************************************************************
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;
    logic addr_ok;
    logic [7:0] a_idx;

    // control registers
    logic hbr_format_select_ff;
    logic hbr_format_override_ff;
    logic onebit_iface_override_ff;
    logic onebit_iface_select_ff;
    logic [1:0] serial_framing_select_ff;
    logic [4:0] justified_word_width_ff;
    logic [2:0] onebit_pin_rotation_ff;
    logic onebit_order_reverse_ff;
    logic [1:0] pcm_pin_rotation_ff;
    logic pcm_order_reverse_ff;
    logic [2:0] master_clock_multiplier_ff;

    // status
    aor_iface_t iface;
    aor_hbr_fmt_t hbr_fmt;
    logic fs_locked_ff;

    assign a_idx = i_haddr[9:2];
    assign addr_ok = (i_haddr[31:10] == 22'h0) && (i_haddr[1:0] == 2'b00);
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = rdata_ff;

    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
        end else begin
            wr_pend_ff <= i_hsel && i_hready && i_htrans[1] && i_hwrite && addr_ok;
            wr_idx_ff <= a_idx;
        end
    end

    // read data chosen in address phase
    always_comb begin
        nxt_rdata = 32'h0;
        if (a_idx == IDX_IFACE_CTRL) begin
            nxt_rdata[HBR_SEL_BIT] = hbr_format_select_ff;
            nxt_rdata[HBR_OVR_BIT] = hbr_format_override_ff;
            nxt_rdata[OB_OVR_BIT] = onebit_iface_override_ff;
            nxt_rdata[OB_SEL_BIT] = onebit_iface_select_ff;
        end else if (a_idx == IDX_FRAMING) begin
            nxt_rdata[WIDTH_LSB +: 5] = justified_word_width_ff;
            nxt_rdata[FRAMING_LSB +: 2] = serial_framing_select_ff;
        end else if (a_idx == IDX_PIN_MAP) begin
            nxt_rdata[OB_ROT_LSB +: 3] = onebit_pin_rotation_ff;
            nxt_rdata[OB_REV_BIT] = onebit_order_reverse_ff;
            nxt_rdata[PCM_ROT_LSB +: 2] = pcm_pin_rotation_ff;
            nxt_rdata[PCM_REV_BIT] = pcm_order_reverse_ff;
        end else if (a_idx == IDX_MCLK_MULT) begin
            nxt_rdata[MCLK_LSB +: 3] = master_clock_multiplier_ff;
        end else if (a_idx == IDX_STATUS) begin
            nxt_rdata[1:0] = iface;
            nxt_rdata[3:2] = hbr_fmt;
            nxt_rdata[4] = o_audio_flags_en;
            nxt_rdata[5] = fs_locked_ff;
        end
        if (!addr_ok) begin
            nxt_rdata = 32'h0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            rdata_ff <= 32'h0;
        end else if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            hbr_format_select_ff <= 1'b0;
            hbr_format_override_ff <= 1'b0;
            onebit_iface_override_ff <= 1'b0;
            onebit_iface_select_ff <= 1'b0;
        end else if (wr_pend_ff && (wr_idx_ff == IDX_IFACE_CTRL)) begin
            hbr_format_select_ff <= i_hwdata[HBR_SEL_BIT];
            hbr_format_override_ff <= i_hwdata[HBR_OVR_BIT];
            onebit_iface_override_ff <= i_hwdata[OB_OVR_BIT];
            onebit_iface_select_ff <= i_hwdata[OB_SEL_BIT];
        end
    end

    // width only goes to the framers;
    // nothing here enforces 24 bits for hbr
    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            justified_word_width_ff <= WIDTH_RST;
            serial_framing_select_ff <= FRAMING_RST;
        end else if (wr_pend_ff && (wr_idx_ff == IDX_FRAMING)) begin
            justified_word_width_ff <= i_hwdata[WIDTH_LSB +: 5];
            serial_framing_select_ff <= i_hwdata[FRAMING_LSB +: 2];
        end
    end

    // reserved codes fall back to the default, so the mapping stays defined
    // and reads show the value actually used
    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            onebit_pin_rotation_ff <= OB_ROT_RST;
            onebit_order_reverse_ff <= 1'b0;
            pcm_pin_rotation_ff <= 2'b00;
            pcm_order_reverse_ff <= 1'b0;
        end else if (wr_pend_ff && (wr_idx_ff == IDX_PIN_MAP)) begin
            if (i_hwdata[OB_ROT_LSB +: 3] <= OB_ROT_MAX) begin
                onebit_pin_rotation_ff <= i_hwdata[OB_ROT_LSB +: 3];
            end else begin
                onebit_pin_rotation_ff <= OB_ROT_RST;
            end
            onebit_order_reverse_ff <= i_hwdata[OB_REV_BIT];
            pcm_pin_rotation_ff <= i_hwdata[PCM_ROT_LSB +: 2];
            pcm_order_reverse_ff <= i_hwdata[PCM_REV_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            master_clock_multiplier_ff <= MCLK_MULT_RST;
        end else if (wr_pend_ff && (wr_idx_ff == IDX_MCLK_MULT)) begin
            if (i_hwdata[MCLK_LSB +: 3] <= MCLK_MULT_MAX) begin
                master_clock_multiplier_ff <= i_hwdata[MCLK_LSB +: 3];
            end else begin
                master_clock_multiplier_ff <= MCLK_MULT_RST;
            end
        end
    end

    // ************************************************************
    // interface and format selection
    // ************************************************************
    always_comb begin
        if (onebit_iface_override_ff) begin
            iface = onebit_iface_select_ff ? IF_ONEBIT : IF_PCM;
        end else if (i_pkt_type == PKT_ONEBIT) begin
            iface = IF_ONEBIT;
        end else if (i_pkt_type == PKT_HBR) begin
            iface = IF_HBR;
        end else begin
            iface = IF_PCM;
        end
    end

    // framing 11 beats the select bit
    always_comb begin
        if (!hbr_format_override_ff) begin
            hbr_fmt = HBR_CODED;
        end else if (serial_framing_select_ff == FRM_RAW) begin
            hbr_fmt = HBR_AES3;
        end else if (hbr_format_select_ff) begin
            hbr_fmt = HBR_CODED;
        end else begin
            hbr_fmt = HBR_BINARY;
        end
    end

    // ************************************************************
    // pin mapping
    // ************************************************************
    // one-bit: rotate upward, then mirror
    function automatic logic [2:0] ob_src(input logic [2:0] pin, input logic [2:0] rot,
                                          input logic rev);
        logic [3:0] q;
        logic [3:0] s;
        q = rev ? (4'(OB_PINS) - 4'h1 - {1'b0, pin}) : {1'b0, pin};
        s = q + OB_PINS - {1'b0, rot};
        if (s >= OB_PINS) begin
            s = s - OB_PINS;
        end
        return s[2:0];
    endfunction : ob_src

    // pins 1..4: same rotate-then-mirror order
    function automatic logic [1:0] pcm_src(input logic [1:0] k, input logic [1:0] rot,
                                           input logic rev);
        logic [1:0] q;
        q = rev ? (2'h3 - k) : k;
        return q - rot;
    endfunction : pcm_src

    logic [5:0] ob_pins;
    logic [3:0] hbr_streams;
    logic [3:0] pcm_streams;
    logic [3:0] mid_pins;

    // hbr block n is stream n before mapping
    always_comb begin
        if (hbr_fmt == HBR_AES3) begin
            hbr_streams = i_hbr_aes3;
        end else if (hbr_fmt == HBR_BINARY) begin
            hbr_streams = i_hbr_binary;
        end else begin
            hbr_streams = i_hbr_coded;
        end
    end

    assign pcm_streams = (iface == IF_HBR) ? hbr_streams : i_pcm_sd;

    genvar gp;
    generate
        for (gp = 0; gp < 6; gp++) begin : g_ob_pin
            // one index, so any pair works
            assign ob_pins[gp] = i_onebit_ch[ob_src(3'(gp), onebit_pin_rotation_ff,
                                                    onebit_order_reverse_ff)];
        end
        for (gp = 0; gp < 4; gp++) begin : g_pcm_pin
            assign mid_pins[gp] = pcm_streams[pcm_src(2'(gp), pcm_pin_rotation_ff,
                                                      pcm_order_reverse_ff)];
        end
    endgenerate

    // ch0/ch1 stay the main pair
    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            o_audio_pin <= 6'h00;
        end else if (iface == IF_ONEBIT) begin
            o_audio_pin <= ob_pins;
        end else begin
            o_audio_pin <= {1'b0, mid_pins, i_coded_stream0};
        end
    end

    // ************************************************************
    // side outputs
    // ************************************************************
    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            o_serial_framing_select <= FRM_I2S;
            o_justified_word_width <= WIDTH_RST;
            o_audio_flags_en <= 1'b1;
            o_hbr_active <= 1'b0;
        end else begin
            o_serial_framing_select <= aor_framing_t'(serial_framing_select_ff);
            o_justified_word_width <= justified_word_width_ff;
            o_audio_flags_en <= !((iface == IF_HBR) && (hbr_fmt == HBR_BINARY));
            o_hbr_active <= (iface == IF_HBR);
        end
    end

    // ************************************************************
    // word clock period
    // ************************************************************
    logic wclk_meta_ff;
    logic wclk_sync_ff;
    logic wclk_prev_ff;
    logic wclk_rise;
    logic [15:0] per_cnt_ff;
    logic [15:0] period_ff;

    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            wclk_meta_ff <= 1'b0;
            wclk_sync_ff <= 1'b0;
            wclk_prev_ff <= 1'b0;
        end else begin
            wclk_meta_ff <= i_link_wclk;
            wclk_sync_ff <= wclk_meta_ff;
            wclk_prev_ff <= wclk_sync_ff;
        end
    end

    assign wclk_rise = wclk_sync_ff && !wclk_prev_ff;

    // counting starts at the first edge, so a
    // partial period never reaches mclk
    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            per_cnt_ff <= 16'h0000;
            period_ff <= 16'h0000;
            fs_locked_ff <= 1'b0;
        end else if (wclk_rise) begin
            per_cnt_ff <= 16'h0001;
            period_ff <= per_cnt_ff;
            fs_locked_ff <= (per_cnt_ff != 16'h0000);
        end else if ((per_cnt_ff != 16'h0000) && (per_cnt_ff != 16'hffff)) begin
            per_cnt_ff <= per_cnt_ff + 16'h0001;
        end
    end

    // ************************************************************
    // master clock accumulator
    // ************************************************************
    // resolution is one i_clk_sys cycle; fast mclk
    // aliases, traded for a single clock
    logic [10:0] mclk_step;
    logic [17:0] acc_ff;
    logic [17:0] nxt_acc;
    logic mclk_ff;
    logic mclk_flip;

    assign mclk_step = 11'(({8'h00, master_clock_multiplier_ff} + 11'h001) * MCLK_BASE_HALF);

    always_comb begin
        nxt_acc = acc_ff + {7'h00, mclk_step};
        mclk_flip = 1'b0;
        if (nxt_acc >= {2'b00, period_ff}) begin
            nxt_acc = nxt_acc - {2'b00, period_ff};
            mclk_flip = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            acc_ff <= 18'h00000;
            mclk_ff <= 1'b0;
        end else if (!fs_locked_ff || (period_ff == 16'h0000)) begin
            acc_ff <= 18'h00000;
            mclk_ff <= 1'b0;
        end else begin
            acc_ff <= (nxt_acc >= {2'b00, period_ff}) ? 18'h00000 : nxt_acc;
            mclk_ff <= mclk_ff ^ mclk_flip;
        end
    end

    assign o_master_clock_out = mclk_ff;

endmodule : aor_top

// File: src/aor_pkg.sv
// shared constants of the audio output router.
// register indices, field positions, resets, encodings.
// assumes byte address = index * 4.
package aor_pkg;

    // ************************************************************
    // register indices (byte address = index * 4)
    // ************************************************************
    localparam logic [7:0] IDX_IFACE_CTRL = 8'h01;
    localparam logic [7:0] IDX_FRAMING = 8'h03;
    localparam logic [7:0] IDX_PIN_MAP = 8'h6d;
    localparam logic [7:0] IDX_MCLK_MULT = 8'hb5;
    localparam logic [7:0] IDX_STATUS = 8'hc0;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int HBR_SEL_BIT = 1;
    localparam int HBR_OVR_BIT = 2;
    localparam int OB_OVR_BIT = 3;
    localparam int OB_SEL_BIT = 4;
    localparam int WIDTH_LSB = 0;
    localparam int FRAMING_LSB = 5;
    localparam int OB_ROT_LSB = 0;
    localparam int OB_REV_BIT = 3;
    localparam int PCM_ROT_LSB = 4;
    localparam int PCM_REV_BIT = 6;
    localparam int MCLK_LSB = 0;

    // ************************************************************
    // values after reset and limits
    // ************************************************************
    localparam logic [4:0] WIDTH_RST = 5'h18;
    localparam logic [1:0] FRAMING_RST = 2'h0;
    localparam logic [2:0] OB_ROT_RST = 3'h0;
    localparam logic [2:0] OB_ROT_MAX = 3'h5;
    localparam logic [2:0] MCLK_MULT_RST = 3'h1;
    localparam logic [2:0] MCLK_MULT_MAX = 3'h5;
    localparam logic [3:0] OB_PINS = 4'h6;
    localparam logic [10:0] MCLK_BASE_HALF = 11'h100;

    // ************************************************************
    // encodings
    // ************************************************************
    typedef enum logic [1:0] {
        FRM_I2S = 2'b00,
        FRM_RJ = 2'b01,
        FRM_LJ = 2'b10,
        FRM_RAW = 2'b11
    } aor_framing_t;

    typedef enum logic [1:0] {
        PKT_NONE = 2'b00,
        PKT_SAMPLE = 2'b01,
        PKT_ONEBIT = 2'b10,
        PKT_HBR = 2'b11
    } aor_pkt_t;

    typedef enum logic [1:0] {
        IF_PCM = 2'b00,
        IF_ONEBIT = 2'b01,
        IF_HBR = 2'b10
    } aor_iface_t;

    typedef enum logic [1:0] {
        HBR_CODED = 2'b00,
        HBR_BINARY = 2'b01,
        HBR_AES3 = 2'b10
    } aor_hbr_fmt_t;

endpackage : aor_pkg

// File: testbench/aor_properties.sv
// checks interface choice, hbr pins and flags.
// assumes a bind to aor_top, ports only.
`timescale 1ns/1ps
module aor_properties
    import aor_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire aor_pkg::aor_pkt_t i_pkt_type,
    input wire logic [5:0] i_onebit_ch,
    input wire logic i_coded_stream0,
    input wire logic [5:0] o_audio_pin,
    input wire logic o_audio_flags_en,
    input wire logic o_hbr_active
);
    // ************************************************************
    // override shadow from bus writes
    // ************************************************************
    logic wr_ff;
    logic ctl_ff;
    logic ovr_ff;
    logic sel_ff;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ff <= 1'b0;
            ctl_ff <= 1'b0;
        end else begin
            wr_ff <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
            ctl_ff <= (i_haddr == {22'h0, IDX_IFACE_CTRL, 2'b00});
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ovr_ff <= 1'b0;
            sel_ff <= 1'b0;
        end else if (wr_ff && ctl_ff) begin
            ovr_ff <= i_hwdata[OB_OVR_BIT];
            sel_ff <= i_hwdata[OB_SEL_BIT];
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // ************************************************************
    // properties
    // ************************************************************
    AST_HBR_PIN0: assert property (o_hbr_active |-> o_audio_pin[0] == $past(i_coded_stream0))
        else $error("pin 0 not coded stream 0");
    AST_HBR_PIN5: assert property (o_hbr_active |-> !o_audio_pin[5])
        else $error("pin 5 driven in hbr");
    AST_FLAGS_HBR: assert property (!o_audio_flags_en |-> o_hbr_active)
        else $error("flags off outside hbr");
    AST_AUTO_HBR: assert property (!$past(ovr_ff) && $past(i_pkt_type) == PKT_HBR |-> o_hbr_active)
        else $error("auto hbr not routed");
    AST_OVR_PCM: assert property ($past(ovr_ff) && !$past(sel_ff) |->
        !o_hbr_active && !o_audio_pin[5] && o_audio_pin[0] == $past(i_coded_stream0))
        else $error("pcm override not obeyed");
    AST_OVR_ONEBIT: assert property ($past(ovr_ff) && $past(sel_ff) |->
        !o_hbr_active && $countones(o_audio_pin) == $countones($past(i_onebit_ch)))
        else $error("one-bit override not obeyed");
    AST_AUTO_ONEBIT: assert property (!$past(ovr_ff) && $past(i_pkt_type) == PKT_ONEBIT |->
        ##0 !o_hbr_active && $countones(o_audio_pin) == $countones($past(i_onebit_ch)))
        else $error("auto one-bit not routed");
    AST_AUTO_PCM: assert property (!$past(ovr_ff) && $past(i_pkt_type[1]) == 1'b0 |->
        !o_hbr_active && !o_audio_pin[5])
        else $error("auto pcm not chosen");
endmodule : aor_properties

bind aor_top aor_properties u_aor_properties (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .i_pkt_type(i_pkt_type),
    .i_onebit_ch(i_onebit_ch), .i_coded_stream0(i_coded_stream0), .o_audio_pin(o_audio_pin),
    .o_audio_flags_en(o_audio_flags_en), .o_hbr_active(o_hbr_active));

// File: testbench/aor_dac_model.sv
// decoder model: word clock source, stereo sink.
// word clock runs free of the system clock.
`timescale 1ns/1ps
module aor_dac_model (
    output logic o_link_wclk,
    input wire logic [5:0] i_audio_pin,
    output logic [1:0] o_stereo
);
    initial begin
        o_link_wclk = 1'b0;
        #37;
        forever #400 o_link_wclk = ~o_link_wclk;
    end
    // stereo uses ch0/ch1 only
    assign o_stereo = i_audio_pin[1:0];
endmodule : aor_dac_model

// File: testbench/aor_top_tb.sv
// self-checking bench over ahb-lite.
// one slave: hready is hreadyout.
`timescale 1ns/1ps
module aor_top_tb;
    import aor_pkg::*;
    logic clk, rst_b, hsel, hwrite, hready, hresp, c0, wclk, mclk, flags, hbr;
    logic [31:0] haddr, hwdata, hrdata, dummy;
    logic [1:0] htrans, stereo;
    logic [5:0] ch, pins;
    logic [3:0] pcm, coded, bin, aes;
    logic [4:0] width;
    aor_pkt_t pkt;
    aor_framing_t frm_o;
    int fails, samples_checked;
    aor_top u_aor_top (.i_clk_sys(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_pkt_type(pkt), .i_onebit_ch(ch), .i_pcm_sd(pcm), .i_hbr_coded(coded),
        .i_hbr_binary(bin), .i_hbr_aes3(aes), .i_coded_stream0(c0), .i_link_wclk(wclk),
        .o_audio_pin(pins), .o_master_clock_out(mclk), .o_serial_framing_select(frm_o),
        .o_justified_word_width(width), .o_audio_flags_en(flags), .o_hbr_active(hbr));
    aor_dac_model u_aor_dac_model (.o_link_wclk(wclk), .i_audio_pin(pins), .o_stereo(stereo));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic close_out();
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask : chk
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            close_out();
        end
    endtask : edge_ready
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        edge_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
    endtask : bus
    task automatic wreg(input logic [7:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, wd, dummy);
    endtask : wreg
    task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        chk(nm, rd, exp);
    endtask : rchk
    function automatic logic [5:0] map1(logic [5:0] c, int rot, logic rev);
        for (int p = 0; p < 6; p++) map1[p] = c[((rev ? 5 - p : p) - rot + 6) % 6];
    endfunction : map1
    function automatic logic [5:0] map4(logic [3:0] s, int rot, logic rev, logic z);
        map4 = {1'b0, 4'h0, z};
        for (int k = 0; k < 4; k++) map4[k + 1] = s[((rev ? 3 - k : k) - rot + 4) % 4];
    endfunction : map4
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs();
        rchk("iface_ctrl", IDX_IFACE_CTRL, 32'h0);
        rchk("framing", IDX_FRAMING, 32'h18);
        rchk("pin_map", IDX_PIN_MAP, 32'h0);
        rchk("mclk_mult", IDX_MCLK_MULT, 32'h1);
        rchk("unmapped", 8'h40, 32'h0);
        wreg(IDX_MCLK_MULT, 32'h5);
        rchk("mclk_max", IDX_MCLK_MULT, 32'h5);
        wreg(IDX_MCLK_MULT, 32'h7);
        rchk("mclk_bad", IDX_MCLK_MULT, 32'h1);
        wreg(IDX_PIN_MAP, 32'h6);
        rchk("rot_bad", IDX_PIN_MAP, 32'h0);
    endtask : t_regs
    task automatic t_onebit();
        wreg(IDX_IFACE_CTRL, 32'h18);
        for (int rv = 0; rv < 2; rv++) begin
            for (int r = 0; r < 6; r++) begin
                wreg(IDX_PIN_MAP, 32'(rv * 8 + r));
                for (int c = 0; c < 6; c++) begin
                    ch <= 6'(1 << c);
                    repeat (2) @(posedge clk);
                    chk("onebit_pins", 32'(pins), 32'(map1(6'(1 << c), r, rv[0])));
                end
            end
        end
    endtask : t_onebit
    task automatic t_hbr_map();
        wreg(IDX_IFACE_CTRL, 32'h0);
        pkt <= PKT_HBR;
        for (int rv = 0; rv < 2; rv++) begin
            for (int r = 0; r < 4; r++) begin
                wreg(IDX_PIN_MAP, 32'(rv * 64 + r * 16));
                for (int k = 0; k < 4; k++) begin
                    coded <= 4'(1 << k);
                    c0 <= k[0];
                    repeat (2) @(posedge clk);
                    chk("hbr_pins", 32'(pins), 32'(map4(4'(1 << k), r, rv[0], k[0])));
                    chk("hbr_active", 32'(hbr), 32'h1);
                end
            end
        end
    endtask : t_hbr_map
    task automatic t_fmt();
        logic [7:0] tbl [8] = '{8'h41, 8'h31, 8'hc1, 8'h82, 8'h92, 8'ha2, 8'hb4, 8'hf4};
        wreg(IDX_PIN_MAP, 32'h0);
        coded <= 4'h1;
        bin <= 4'h2;
        aes <= 4'h4;
        foreach (tbl[i]) begin
            wreg(IDX_IFACE_CTRL, {29'h0, tbl[i][7], tbl[i][6], 1'b0});
            wreg(IDX_FRAMING, {25'h0, tbl[i][5:4], 5'h18});
            repeat (2) @(posedge clk);
            chk("hbr_format", 32'(pins[4:1]), 32'(tbl[i][3:0]));
            chk("flags_en", 32'(flags), 32'(tbl[i][3:0] != 4'h2));
            chk("framing_out", 32'(frm_o), 32'(tbl[i][5:4]));
        end
        wreg(IDX_FRAMING, 32'h18);
    endtask : t_fmt
    task automatic t_auto();
        pcm <= 4'h9;
        ch <= 6'h2d;
        for (int i = 0; i < 4; i++) begin
            wreg(IDX_IFACE_CTRL, i == 3 ? 32'h8 : 32'h0);
            pkt <= i < 3 ? aor_pkt_t'(i) : PKT_ONEBIT;
            repeat (2) @(posedge clk);
            chk("auto_pins", 32'(pins), 32'(i == 2 ? 6'h2d : map4(4'h9, 0, 1'b0, c0)));
        end
    endtask : t_auto
    task automatic t_mclk(input logic [2:0] nv);
        logic [31:0] st;
        int k;
        int tg;
        logic prev;
        wreg(IDX_MCLK_MULT, {29'h0, nv});
        k = 0;
        st = 32'h0;
        while (st[5] !== 1'b1 && k < 64) begin
            bus(1'b0, IDX_STATUS, 32'h0, st);
            k++;
        end
        chk("fs_lock", {31'h0, st[5]}, 32'h1);
        tg = 0;
        prev = mclk;
        repeat (32) begin
            @(posedge clk);
            if (mclk !== prev) tg++;
            prev = mclk;
        end
        chk("mclk_toggles", 32'(tg), 32'd32);
    endtask : t_mclk
    initial begin
        fails = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pkt = PKT_NONE;
        ch = 6'h0;
        pcm = 4'h0;
        coded = 4'h0;
        bin = 4'h0;
        aes = 4'h0;
        c0 = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_onebit();
        t_hbr_map();
        t_fmt();
        t_auto();
        t_mclk(3'h0);
        t_mclk(3'h5);
        close_out();
    end
endmodule : aor_top_tb
